// ===== core/eil_pkg.sv
package eil_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [3:0] EIL_ADDR_SCR = 4'h0;
	localparam logic [3:0] EIL_ADDR_BRK = 4'h1;
	localparam logic [3:0] EIL_ADDR_STAT = 4'h2;
	localparam logic [3:0] EIL_ADDR_MASK = 4'h3;

	// status/control field positions
	localparam int EIL_BIT_MODE = 0;
	localparam int EIL_BIT_LMASK = 1;
	localparam int EIL_BIT_ACK = 2;
	localparam int EIL_BIT_PEND = 3;
	// break control field
	localparam int EIL_BIT_BRK_CLR = 7;
	// event status bits
	localparam int EIL_EV_LATCH = 0;
	localparam int EIL_EV_FETCH = 1;
	localparam int EIL_NUM_EV = 2;

	localparam logic [7:0] EIL_RST_BYTE = 8'h00;
	localparam logic [1:0] EIL_RST_EV = 2'h0;

	// ---------------------------------------------------------------
	// bus carrier and state types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} eil_bus_req_t;

	typedef enum logic [1:0] {
		EIL_IDLE = 2'b00,
		EIL_PEND = 2'b01,
		EIL_HOLD = 2'b10
	} eil_state_t;

endpackage

// ===== core/eil_sync.sv
`timescale 1ns/10ps
`default_nettype none
module eil_sync (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_async,
	output logic o_sync
);
	typedef struct packed {
		logic s1;
		logic s2;
	} eil_sync_st_t;

	eil_sync_st_t st_q, st_d;

	always_comb begin
		st_d.s1 = i_async;
		st_d.s2 = st_q.s1;
	end

	// reset to idle-high: the pin is active low
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			st_q <= 2'h3;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_sync = st_q.s2;
endmodule
`default_nettype wire

// ===== core/eil_edge.sv
`timescale 1ns/10ps
`default_nettype none
module eil_edge (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_lvl,
	output logic o_fall,
	output logic o_prev
);
	logic prev_q;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= i_lvl;
		end
	end

	assign o_fall = prev_q & ~i_lvl;
	assign o_prev = prev_q;
endmodule
`default_nettype wire

// ===== core/eil_top.sv
// Functional notes
// - low pin sets request latch
// - vector fetch acknowledge clears the latch
// - writing ack one clears the latch
// - reset clears the latch
// - mode one edge+level, zero edge only
// - edge mode: latch holds until acknowledge
// - level mode: needs acknowledge and pin high
// - reset clears latch and mode bit
// - local mask withholds request from cpu
// - pending flag readable regardless of mask
// - ack bit write-only, reads zero
// - edge after acknowledge latches again
// - cpu vectors through fixed vector pair
// - break clear by ack write only with clear enable
// - clear enable zero: ack writes in break ignored
// - pin level offered to branch instructions
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module eil_top
	import eil_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_irq_pin_b,
	input wire logic i_vec_fetch_ack,
	input wire logic i_break_state,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_irq_req,
	output logic o_pin_level,
	output logic o_int
);
	import eil_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		eil_state_t fsm;
		logic mode;
		logic lmask;
		logic brk_clr_en;
		logic [EIL_NUM_EV-1:0] ev_stat;
		logic [EIL_NUM_EV-1:0] ev_mask;
		logic [7:0] rdata;
		logic irq_req;
		logic pin_lvl;
		logic intr;
	} eil_st_t;

	eil_st_t st_q, st_d;
	eil_bus_req_t bus;
	logic pin_s, pin_fall, pin_prev;
	logic sw_ack, ack, trig, pend;

	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// ---------------------------------------------------------------
	// pin conditioning
	// ---------------------------------------------------------------
	eil_sync u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_async(i_irq_pin_b),
		.o_sync(pin_s)
	);

	eil_edge u_edge (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_lvl(pin_s),
		.o_fall(pin_fall),
		.o_prev(pin_prev)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		// software ack gated in break by clear enable
		sw_ack = bus.wr && bus.addr == EIL_ADDR_SCR &&
			bus.wdata[EIL_BIT_ACK] &&
			(!i_break_state || st_q.brk_clr_en);
		ack = sw_ack || i_vec_fetch_ack;
		trig = pin_fall || (st_q.mode && !pin_s);
		case (st_q.fsm)
		EIL_IDLE: begin
			if (trig) begin
				st_d.fsm = EIL_PEND;
			end
		end
		EIL_PEND: begin
			if (ack) begin
				if (st_q.mode && !pin_s) begin
					st_d.fsm = EIL_HOLD;
				end else if (pin_fall) begin
					st_d.fsm = EIL_PEND;
				end else begin
					st_d.fsm = EIL_IDLE;
				end
			end
		end
		EIL_HOLD: begin
			// acknowledged, waiting for pin high
			if (!st_q.mode) begin
				st_d.fsm = pin_fall ? EIL_PEND : EIL_IDLE;
			end else if (pin_s) begin
				st_d.fsm = EIL_IDLE;
			end
		end
		default: begin
			st_d.fsm = EIL_IDLE;
		end
		endcase
		pend = st_d.fsm != EIL_IDLE;
		if (bus.wr && bus.addr == EIL_ADDR_SCR) begin
			st_d.mode = bus.wdata[EIL_BIT_MODE];
			st_d.lmask = bus.wdata[EIL_BIT_LMASK];
		end
		if (bus.wr && bus.addr == EIL_ADDR_BRK) begin
			st_d.brk_clr_en = bus.wdata[EIL_BIT_BRK_CLR];
		end
		if (bus.wr && bus.addr == EIL_ADDR_MASK) begin
			st_d.ev_mask = bus.wdata[EIL_NUM_EV-1:0];
		end
		// write-one-to-clear, set wins
		if (bus.wr && bus.addr == EIL_ADDR_STAT) begin
			st_d.ev_stat = st_q.ev_stat & ~bus.wdata[EIL_NUM_EV-1:0];
		end
		if (st_q.fsm == EIL_IDLE && pend) begin
			st_d.ev_stat[EIL_EV_LATCH] = 1'b1;
		end
		if (i_vec_fetch_ack) begin
			st_d.ev_stat[EIL_EV_FETCH] = 1'b1;
		end
		st_d.rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
			EIL_ADDR_SCR: begin
				// ack bit always reads zero
				st_d.rdata[EIL_BIT_PEND] = st_q.fsm != EIL_IDLE;
				st_d.rdata[EIL_BIT_LMASK] = st_q.lmask;
				st_d.rdata[EIL_BIT_MODE] = st_q.mode;
			end
			EIL_ADDR_BRK: begin
				st_d.rdata[EIL_BIT_BRK_CLR] = st_q.brk_clr_en;
			end
			EIL_ADDR_STAT: begin
				st_d.rdata[EIL_NUM_EV-1:0] = st_q.ev_stat;
			end
			EIL_ADDR_MASK: begin
				st_d.rdata[EIL_NUM_EV-1:0] = st_q.ev_mask;
			end
			default: begin
				st_d.rdata = 8'h00;
			end
			endcase
		end
		// cpu applies its global mask and vector pair
		st_d.irq_req = pend && !st_d.lmask;
		st_d.pin_lvl = pin_s;
		st_d.intr = |(st_d.ev_stat & ~st_d.ev_mask);
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			st_q.fsm <= EIL_IDLE;
			st_q.mode <= EIL_RST_BYTE[EIL_BIT_MODE];
			st_q.lmask <= EIL_RST_BYTE[EIL_BIT_LMASK];
			st_q.brk_clr_en <= EIL_RST_BYTE[EIL_BIT_BRK_CLR];
			st_q.ev_stat <= EIL_RST_EV;
			st_q.ev_mask <= EIL_RST_EV;
			st_q.rdata <= EIL_RST_BYTE;
			st_q.irq_req <= 1'b0;
			st_q.pin_lvl <= 1'b1;
			st_q.intr <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_rdata = st_q.rdata;
	assign o_irq_req = st_q.irq_req;
	assign o_pin_level = st_q.pin_lvl;
	assign o_int = st_q.intr;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	sequence s_sw_ack;
		bus.wr && bus.addr == EIL_ADDR_SCR && bus.wdata[EIL_BIT_ACK];
	endsequence

	property p_fall_sets;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		pin_prev && !pin_s && st_q.fsm == EIL_IDLE |=>
			st_q.fsm == EIL_PEND;
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("edge lost");

	property p_fetch_clears;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_vec_fetch_ack && !st_q.mode && !pin_fall |=> st_q.fsm == EIL_IDLE;
	endproperty
	a_fetch_clears: assert property (p_fetch_clears) else $error("fetch");

	property p_sw_clears;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		s_sw_ack and (!i_break_state && !st_q.mode && !pin_fall) |=>
			st_q.fsm == EIL_IDLE;
	endproperty
	a_sw_clears: assert property (p_sw_clears) else $error("sw ack");

	property p_level_hold;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		st_q.mode && !pin_s && !(bus.wr && bus.addr == EIL_ADDR_SCR) |=>
			st_q.fsm != EIL_IDLE;
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level drop");

	property p_mask;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		st_q.lmask |-> !st_q.irq_req;
	endproperty
	a_mask: assert property (p_mask) else $error("masked req");

	property p_pend_read;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		bus.rd && bus.addr == EIL_ADDR_SCR |=>
			o_rdata[EIL_BIT_PEND] == $past(st_q.fsm != EIL_IDLE) &&
			!o_rdata[EIL_BIT_ACK];
	endproperty
	a_pend_read: assert property (p_pend_read) else $error("flag read");

	property p_break_protect;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		s_sw_ack and (i_break_state && !st_q.brk_clr_en &&
			!i_vec_fetch_ack && st_q.fsm == EIL_PEND) |=>
			st_q.fsm == EIL_PEND;
	endproperty
	a_break_protect: assert property (p_break_protect)
		else $error("break");

	property p_pin_level;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		##2 1 |-> o_pin_level == $past(pin_s);
	endproperty
	a_pin_level: assert property (p_pin_level) else $error("pin lvl");

	property p_reset_clear;
		@(posedge i_sys_clk)
		!i_rst_b |=> st_q.fsm == EIL_IDLE && !st_q.mode;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset");
endmodule
`default_nettype wire

// ===== testbench/eil_src.sv
`timescale 1ns/10ps
`default_nettype none
module eil_src (
	input wire logic i_sys_clk,
	input wire logic i_low,
	output logic o_pin_b
);
	// ---------------------------------------------------------------
	// pin source
	// ---------------------------------------------------------------
	// pull-up keeps the line high while the source is idle
	initial o_pin_b = 1'h1;
	always @(posedge i_sys_clk) begin
		o_pin_b <= ~i_low;
	end
endmodule
`default_nettype wire

// ===== testbench/external_interrupt_latch_tb.sv
`timescale 1ns/10ps
`default_nettype none
module external_interrupt_latch_tb;
	import eil_pkg::*;
	logic i_sys_clk, i_rst_b, i_vec_fetch_ack, i_break_state, i_wr, i_rd;
	logic [3:0] i_addr;
	logic [7:0] i_wdata, o_rdata, v;
	logic o_irq_req, o_pin_level, o_int, lo, pin_b;
	int errors, tests_run;
	eil_top i_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.i_irq_pin_b(pin_b), .i_vec_fetch_ack(i_vec_fetch_ack),
		.i_break_state(i_break_state), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq_req(o_irq_req),
		.o_pin_level(o_pin_level), .o_int(o_int));
	eil_src i_src (.i_sys_clk(i_sys_clk), .i_low(lo), .o_pin_b(pin_b));
	// ---------------------------------------------------------------
	// bus and compare tasks
	// ---------------------------------------------------------------
	task chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'h1;
		@(posedge i_sys_clk);
		i_wr <= 1'h0;
		#1;
	endtask
	task rc(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'h1;
		@(posedge i_sys_clk);
		i_rd <= 1'h0;
		#1 v = o_rdata;
		chk(v, e);
	endtask
	// bit1 pin level, bit0 request
	task so(input logic [7:0] e);
		chk({6'h00, o_pin_level, o_irq_req}, e);
	endtask
	// covers two sync stages, edge stage and the source flop
	task pin(input logic l);
		@(posedge i_sys_clk);
		lo <= l;
		repeat (6) @(posedge i_sys_clk);
		#1;
	endtask
	task vf;
		@(posedge i_sys_clk);
		i_vec_fetch_ack <= 1'h1;
		@(posedge i_sys_clk);
		i_vec_fetch_ack <= 1'h0;
		#1;
	endtask
	task give_verdict;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_reset;
		rc(EIL_ADDR_SCR, 8'h00);
		rc(EIL_ADDR_BRK, 8'h00);
		rc(EIL_ADDR_STAT, 8'h00);
		rc(EIL_ADDR_MASK, 8'h00);
		rc(4'hF, 8'h00);
		so(8'h02);
		chk({7'h00, o_int}, 8'h00);
		$display("test reset done");
	endtask
	task t_edge;
		pin(1'h1);
		so(8'h01);
		rc(EIL_ADDR_SCR, 8'h08);
		rc(EIL_ADDR_STAT, 8'h01);
		chk({7'h00, o_int}, 8'h01);
		wr(EIL_ADDR_SCR, 8'h04);
		rc(EIL_ADDR_SCR, 8'h00);
		so(8'h00);
		pin(1'h0);
		pin(1'h1);
		rc(EIL_ADDR_SCR, 8'h08);
		wr(EIL_ADDR_MASK, 8'h03);
		chk({7'h00, o_int}, 8'h00);
		wr(EIL_ADDR_STAT, 8'h01);
		wr(EIL_ADDR_MASK, 8'h00);
		wr(EIL_ADDR_SCR, 8'h02);
		rc(EIL_ADDR_SCR, 8'h0A);
		so(8'h00);
		vf();
		rc(EIL_ADDR_SCR, 8'h02);
		rc(EIL_ADDR_STAT, 8'h02);
		wr(EIL_ADDR_STAT, 8'h03);
		chk({7'h00, o_int}, 8'h00);
		wr(EIL_ADDR_SCR, 8'h00);
		pin(1'h0);
		$display("test edge done");
	endtask
	task t_level;
		wr(EIL_ADDR_SCR, 8'h01);
		pin(1'h1);
		wr(EIL_ADDR_SCR, 8'h05);
		rc(EIL_ADDR_SCR, 8'h09);
		pin(1'h0);
		rc(EIL_ADDR_SCR, 8'h01);
		so(8'h02);
		pin(1'h1);
		pin(1'h0);
		rc(EIL_ADDR_SCR, 8'h09);
		vf();
		rc(EIL_ADDR_SCR, 8'h01);
		$display("test level done");
	endtask
	task t_break;
		wr(EIL_ADDR_SCR, 8'h00);
		pin(1'h1);
		i_break_state <= 1'h1;
		wr(EIL_ADDR_SCR, 8'h04);
		rc(EIL_ADDR_SCR, 8'h08);
		wr(EIL_ADDR_BRK, 8'h80);
		wr(EIL_ADDR_SCR, 8'h04);
		rc(EIL_ADDR_SCR, 8'h00);
		i_break_state <= 1'h0;
		rc(EIL_ADDR_SCR, 8'h00);
		wr(EIL_ADDR_BRK, 8'h00);
		pin(1'h0);
		$display("test break done");
	endtask
	task t_rstmid;
		wr(EIL_ADDR_SCR, 8'h03);
		pin(1'h1);
		i_rst_b <= 1'h0;
		repeat (10) @(posedge i_sys_clk);
		#1 so(8'h02);
		i_rst_b <= 1'h1;
		rc(EIL_ADDR_SCR, 8'h00);
		pin(1'h0);
		$display("test mid reset done");
	endtask
	// ---------------------------------------------------------------
	// clock, sequence, watchdog
	// ---------------------------------------------------------------
	initial begin
		i_sys_clk = 1'h0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end
	initial begin
		{i_rst_b, i_vec_fetch_ack, i_break_state, i_wr, i_rd, lo} = 6'h00;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		repeat (10) @(posedge i_sys_clk);
		i_rst_b <= 1'h1;
		t_reset();
		t_edge();
		t_level();
		t_break();
		t_rstmid();
		give_verdict();
	end
	initial begin
		#200000;
		errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
